// ---- bench/brc_branch_return_properties.sv ----
// port checker of the branch and return sequencer
`timescale 1ns/1ns
`default_nettype none
`include "brc_cfg.svh"
module brc_branch_return_properties #(
  parameter int PC_W = 14,
  parameter int SP_W = 8
) (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic [PC_W-1:0]      fetchAddr,
  input wire logic [7:0]           progByte,
  input wire logic [7:0]           stackByte,
  input wire logic [7:0]           pairWx,
  input wire logic [7:0]           pairEa,
  input wire logic                 spWrite,
  input wire logic [SP_W-1:0]      stackPointer,
  input wire brc_pkg::brc_status_t statusOut,
  input wire logic                 statusLoad,
  input wire logic                 intWindow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // page and block come from the address past the two-byte opcode
  wire logic [PC_W-1:0] pcPlus2 = fetchAddr + 14'h0002;
  wire logic [7:0]      pairSel = (progByte == `BRC_OP2_WX) ? pairWx : pairEa;
  // return: decode, two busy cycles, then the restored boundary
  sequence retStart;
    intWindow && progByte == `BRC_OP_RETI;
  endsequence
  sequence retBody;
    !intWindow [*2] ##1 (intWindow && statusLoad);
  endsequence
  AST_RET_CYCLES: assert property (retStart |=> retBody)
    else $error("return did not end after three cycles");
  AST_RET_SP: assert property (
    (retStart and !spWrite) ##1 !spWrite [*2] |=>
    stackPointer == $past(stackPointer, 3) + 8'h06)
    else $error("stack pointer not advanced by six");
  AST_RET_PC: assert property (retStart |-> ##3 fetchAddr ==
    {$past(stackByte[5:4], 3), $past(stackByte[3:0], 3),
     $past(stackByte[7:4], 2), $past(stackByte[3:0], 2)})
    else $error("return address not restored from frame");
  AST_RET_STATUS: assert property (retStart |-> ##3 statusLoad &&
    statusOut == {$past(stackByte[3:0], 1), $past(stackByte[7:4], 1)})
    else $error("status not restored from frame");
  AST_LONG_JUMP: assert property (
    intWindow && progByte == `BRC_OP_LONGJ |-> ##3 intWindow &&
    fetchAddr == {$past(progByte[5:0], 2), $past(progByte, 1)})
    else $error("long jump target wrong");
  AST_SHORT_JUMP: assert property (
    intWindow && progByte[7:4] == `BRC_HI_SHORTJ |-> ##2 intWindow &&
    fetchAddr == {$past(pcPlus2[13:12], 2), $past(progByte[3:0], 2),
                  $past(progByte, 1)})
    else $error("short jump target wrong");
  AST_REL_FWD: assert property (
    intWindow && progByte[7:4] == `BRC_HI_RELFWD && progByte[3:0] != 4'h0
    |=> $stable(fetchAddr) ##1 fetchAddr == $past(fetchAddr, 2) + 14'h0001
        + {10'h000, $past(progByte[3:0], 2)})
    else $error("forward relative target wrong");
  AST_REL_BWD: assert property (
    intWindow && progByte[7:4] == `BRC_HI_RELBWD && progByte[3:0] != 4'h0
    |-> ##2 intWindow && fetchAddr == $past(fetchAddr, 2)
        - {10'h000, $past(progByte[3:0], 2)})
    else $error("backward relative target wrong");
  AST_INDIRECT: assert property (
    intWindow && progByte == `BRC_OP_PREFIX ##1
    (progByte == `BRC_OP2_WX || progByte == `BRC_OP2_EA) |-> ##2
    fetchAddr == {$past(pcPlus2[13:8], 3), $past(pairSel, 2)})
    else $error("indirect jump target wrong");
  // jumps must never disturb carry or the other status bits
  AST_STATUS_HOLD: assert property (!statusLoad |-> $stable(statusOut))
    else $error("status changed outside a return");
endmodule // brc_branch_return_properties
`default_nettype wire

// ---- bench/brc_mem_model.sv ----
// program memory and interrupt stack beside the sequencer
`timescale 1ns/1ns
`default_nettype none
module brc_mem_model (
  input  wire logic [13:0] fetchAddr,
  output logic      [7:0]  progByte,
  input  wire logic [7:0]  stackAddr,
  output logic      [7:0]  stackByte
);
  logic [7:0] rom [16384];
  logic [3:0] stk [256];
  // unwritten bytes read as a non-branch opcode, never unknown
  initial begin
    foreach (rom[i]) rom[i] = 8'hFF;
    foreach (stk[i]) stk[i] = 4'h0;
  end
  // both reads answer in the cycle of the address
  assign progByte  = rom[fetchAddr];
  assign stackByte = {stk[stackAddr + 8'h01], stk[stackAddr]};
endmodule // brc_mem_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// testbench of the branch and return sequencer
`timescale 1ns/1ns
`default_nettype none
`include "brc_cfg.svh"
module tb_top;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic [13:0]          fetchAddr;
  logic [7:0]           progByte, stackAddr, stackByte, stackPointer;
  logic [7:0]           pairWx, pairEa, spWriteValue, otherOpcode;
  logic                 spWrite, statusLoad, intWindow, busy, otherValid;
  brc_pkg::brc_status_t statusOut;
  int                   errCount = 0;
  int                   samplesChecked = 0;
  int                   cycles = 0;
  // address and byte pairs: a chain where each jump lands on the next
  logic [21:0] prog [19] = '{22'h000000, 22'h0001D5, 22'h2FFE9A,
    22'h2FFF34, 22'h3A34DB, 22'h3A3505, 22'h3A36FE, 22'h05FEDD, 22'h05FF64,
    22'h06801F, 22'h06900F, 22'h0681DD, 22'h068260, 22'h06129B, 22'h061300,
    22'h0B001A, 22'h0B0BA7, 22'h0B0CDD, 22'h0B0D11};
  // frame nibbles from FA up; upper two bits of FB are junk on purpose
  logic [23:0] frame = 24'h5AFEEF;

  always #(`BRC_CLK_PERIOD_NS / 2) clk = ~clk;

  brc_branch_return i_brc_branch_return (.clk(clk), .reset_n(reset_n),
    .fetchAddr(fetchAddr), .progByte(progByte), .stackAddr(stackAddr),
    .stackByte(stackByte), .pairWx(pairWx), .pairEa(pairEa),
    .spWrite(spWrite), .spWriteValue(spWriteValue),
    .stackPointer(stackPointer), .statusOut(statusOut),
    .statusLoad(statusLoad), .intWindow(intWindow), .busy(busy),
    .otherOpcode(otherOpcode), .otherValid(otherValid));
  brc_mem_model i_brc_mem_model (.fetchAddr(fetchAddr), .progByte(progByte),
    .stackAddr(stackAddr), .stackByte(stackByte));

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // run n instruction cycles, then expect a boundary at the target
  task automatic go(input int n, input logic [13:0] exp);
    repeat (n) @(posedge clk);
    #1;
    chk(fetchAddr, exp);
    chk(intWindow, 1'b1);
    chk(busy, 1'b0);
    $display("step ended at %h", exp);
  endtask

  // a hang is cut short well past the expected length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      errCount++;
      endOfTest();
    end
  end

  initial begin
    pairWx = 8'h80;
    pairEa = 8'h12;
    spWrite = 1'b0;
    spWriteValue = 8'hFA;
    #1;
    foreach (prog[k]) i_brc_mem_model.rom[prog[k][21:8]] = prog[k][7:0];
    for (int k = 0; k < 6; k++) i_brc_mem_model.stk[8'hFA + k] = frame[4*k+:4];
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    spWrite <= 1'b1;
    // non-branch byte while the stack pointer is loaded
    @(posedge clk);
    spWrite <= 1'b0;
    #1;
    chk(fetchAddr, 14'h0001);
    chk(otherValid, 1'b1);
    chk(stackPointer, 8'hFA);
    // one cycle into the return: busy, second frame pair addressed
    @(posedge clk);
    #1;
    chk(busy, 1'b1);
    chk(stackAddr, 8'hFC);
    go(2, 14'h2FFE);
    chk(stackPointer, 8'h00);
    chk(statusOut, 8'hA5);
    chk(statusLoad, 1'b1);
    go(2, 14'h3A34);
    go(3, 14'h05FE);
    go(3, 14'h0680);
    go(2, 14'h0690);
    go(2, 14'h0681);
    go(3, 14'h0612);
    go(2, 14'h0B00);
    go(2, 14'h0B0B);
    go(1, 14'h0B0C);
    chk(otherValid, 1'b1);
    chk(otherOpcode, 8'hA7);
    chk(statusOut, 8'hA5);
    // prefix with a foreign second byte goes over after two cycles
    go(2, 14'h0B0E);
    chk(otherValid, 1'b1);
    chk(otherOpcode, 8'hDD);
    // mid-run reset, held two edges so no stale sample meets the release
    @(posedge clk);
    reset_n <= 1'b0;
    #1;
    chk(fetchAddr, 14'h0000);
    chk(stackAddr, 8'h00);
    chk(stackPointer, 8'h00);
    chk(statusOut, 8'h00);
    chk(statusLoad, 1'b0);
    chk(otherValid, 1'b0);
    chk(intWindow, 1'b1);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(fetchAddr, 14'h0001);
    chk(otherValid, 1'b1);
    $display("reset test ended");
    endOfTest();
  end
endmodule // tb_top

bind brc_branch_return brc_branch_return_properties #(.PC_W(PC_W),
  .SP_W(SP_W)) i_brc_branch_return_properties (.clk(clk),
  .reset_n(reset_n), .fetchAddr(fetchAddr), .progByte(progByte),
  .stackByte(stackByte), .pairWx(pairWx), .pairEa(pairEa),
  .spWrite(spWrite), .stackPointer(stackPointer), .statusOut(statusOut),
  .statusLoad(statusLoad), .intWindow(intWindow));
`default_nettype wire

// ---- hw/brc_branch_return.sv ----
// program flow sequencer: interrupt return and the jump family
`timescale 1ns/1ns
`default_nettype none
`include "brc_cfg.svh"

module brc_branch_return #(
  parameter int PC_W = 14,
  parameter int SP_W = 8
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // program memory: byte at fetchAddr, same cycle
  output logic              [PC_W-1:0]    fetchAddr,
  input  wire logic         [7:0]         progByte,
  // stack: low nibble at stackAddr, high nibble at stackAddr+1
  output logic              [SP_W-1:0]    stackAddr,
  input  wire logic         [7:0]         stackByte,
  // register pairs used by the indirect jumps
  input  wire logic         [7:0]         pairWx,
  input  wire logic         [7:0]         pairEa,
  // stack pointer load from other instructions
  input  wire logic                       spWrite,
  input  wire logic         [SP_W-1:0]    spWriteValue,
  output logic              [SP_W-1:0]    stackPointer,
  // restored status, with a one-cycle load strobe
  output brc_pkg::brc_status_t            statusOut,
  output logic                            statusLoad,
  // instruction boundary: interrupt entry may be taken
  output logic                            intWindow,
  output logic                            busy,
  // opcode that belongs to another unit
  output logic              [7:0]         otherOpcode,
  output logic                            otherValid
);

  // the frame slicing below assumes these widths
  if (PC_W != 14 || SP_W != 8) begin : gWidthCheck
    $error("brc_branch_return: PC_W must be 14 and SP_W 8");
  end

  // the frame walk must cover exactly the step the return applies
  if (`BRC_FRM_STATUS + 8'h02 != `BRC_SP_STEP) begin : gFrameCheck
    $error("brc_branch_return: frame size and stack step disagree");
  end

  // the state walk below serves exactly these cycle counts
  if (`BRC_CYC_RETI != 3 || `BRC_CYC_LONGJ != 3 ||
      `BRC_CYC_SHORTJ != 2 || `BRC_CYC_RELIMM != 2 ||
      `BRC_CYC_RELIND != 3) begin : gCycleCheck
    $error("brc_branch_return: cycle counts differ from the state walk");
  end

  brc_pkg::brc_state_t   state_q;
  brc_pkg::brc_state_t   state_d;
  logic [PC_W-1:0]       pc_q;
  logic [PC_W-1:0]       pc_d;
  logic [PC_W-1:0]       target_q;
  logic [PC_W-1:0]       target_d;
  logic [SP_W-1:0]       sp_q;
  logic [SP_W-1:0]       sp_d;
  brc_pkg::brc_status_t  status_q;
  brc_pkg::brc_status_t  status_d;
  logic                  statusLoad_q;
  logic                  statusLoad_d;
  logic [7:0]            other_q;
  logic [7:0]            other_d;
  logic                  otherValid_q;
  logic                  otherValid_d;

  brc_pkg::brc_opclass_t opClass;
  logic                  secIsWx;
  logic                  secIsEa;

  // one classifier serves first and second bytes
  brc_opcode_decode uDecode (
    .opByte  (progByte),
    .opClass (opClass),
    .secIsWx (secIsWx),
    .secIsEa (secIsEa)
  );

  // state flags
  wire logic inDecode = (state_q == brc_pkg::ST_DECODE);
  wire logic inReti1  = (state_q == brc_pkg::ST_RETI1);
  wire logic inReti2  = (state_q == brc_pkg::ST_RETI2);

  // address of the byte after the one now fetched
  wire logic [PC_W-1:0] pcNext = pc_q + `BRC_PC_ONE;

  // relative immediate targets; offset field is the low nibble
  wire logic [PC_W-1:0] relOff = {10'h000, progByte[3:0]};
  wire logic [PC_W-1:0] relFwd = pcNext + relOff;
  wire logic [PC_W-1:0] relBwd = pc_q - relOff;

  // indirect pair select and the check that the second byte names a pair
  wire logic [7:0] pairSel = secIsWx ? pairWx : pairEa;
  wire logic       secOk   = secIsWx | secIsEa;

  // stack read address: one nibble pair per cycle, so the six-nibble
  // frame needs three reads: PC 11-8 and 13-12, then PC 3-0 and 7-4,
  // then the interrupt status, bank enables, carry and skip bits
  wire logic [SP_W-1:0] frmOff =
    inReti1 ? `BRC_FRM_PC_LOW :
    inReti2 ? `BRC_FRM_STATUS :
              `BRC_FRM_PC_MID;

  // frame nibbles as they arrive from the stack
  wire logic [3:0] frmLowNib  = stackByte[3:0];
  wire logic [3:0] frmHighNib = stackByte[7:4];

  // status word is the last frame pair
  wire brc_pkg::brc_status_t frmStatus = '{
    intStatHigh : frmLowNib[3],
    intStatLow  : frmLowNib[2],
    memBankEn   : frmLowNib[1],
    regBankEn   : frmLowNib[0],
    carry       : frmHighNib[3],
    skipCond    : frmHighNib[2:0]
  };

  // branch targets, one named wire per form
  wire logic [PC_W-1:0] longTarget  = {target_q[13:8], progByte};
  // block bits from the address after the jump; last two bytes cross
  wire logic [PC_W-1:0] shortTarget =
    {pcNext[13:12], target_q[11:8], progByte};
  // page of the following instruction, pair as low byte
  wire logic [PC_W-1:0] indTarget   = {pcNext[13:8], pairSel};

  // stack pointer: the return's step beats a load from elsewhere
  wire logic [SP_W-1:0] spStep = sp_q + `BRC_SP_STEP;
  wire logic [SP_W-1:0] spLoad = spWrite ? spWriteValue : sp_q;

  // sequencer next state and datapath; cycle plan, decode counted:
  //   return        frame pair one, frame pair two, status pair  (3)
  //   long jump     opcode, high target byte, low target byte    (3)
  //   short jump    opcode and high nibble, low target byte      (2)
  //   relative imm  opcode, then a quiet cycle at the same PC    (2)
  //   indirect      prefix, pair select byte, landing            (3)
  // the quiet relative cycle keeps the two-cycle timing without a
  // second fetch; the byte shown meanwhile is ignored
  always_comb begin
    state_d      = brc_pkg::ST_DECODE;
    pc_d         = pc_q;
    target_d     = target_q;
    sp_d         = spLoad;
    status_d     = status_q;
    statusLoad_d = 1'b0;
    other_d      = other_q;
    otherValid_d = 1'b0;
    case (state_q)
      brc_pkg::ST_DECODE: begin
        case (opClass)
          brc_pkg::OC_RETI: begin
            // first pair: PC 11-8 low, PC 13-12 high; bit 14 absent
            target_d[11:8]  = frmLowNib;
            target_d[13:12] = frmHighNib[1:0];
            state_d         = brc_pkg::ST_RETI1;
          end
          brc_pkg::OC_LONGJ: begin
            pc_d    = pcNext;
            state_d = brc_pkg::ST_LJ1;
          end
          brc_pkg::OC_SHORTJ: begin
            target_d[11:8] = progByte[3:0];
            pc_d           = pcNext;
            state_d        = brc_pkg::ST_SJ1;
          end
          brc_pkg::OC_RELFWD: begin
            target_d = relFwd;
            state_d  = brc_pkg::ST_RJ1;
          end
          brc_pkg::OC_RELBWD: begin
            target_d = relBwd;
            state_d  = brc_pkg::ST_RJ1;
          end
          brc_pkg::OC_PREFIX: begin
            other_d = progByte;
            pc_d    = pcNext;
            state_d = brc_pkg::ST_RI1;
          end
          default: begin
            // not a branch: hand it over and step past it
            other_d      = progByte;
            otherValid_d = 1'b1;
            pc_d         = pcNext;
          end
        endcase
      end
      brc_pkg::ST_RETI1: begin
        target_d[3:0] = frmLowNib;
        target_d[7:4] = frmHighNib;
        state_d       = brc_pkg::ST_RETI2;
      end
      brc_pkg::ST_RETI2: begin
        pc_d         = target_q;
        sp_d         = spStep;
        status_d     = frmStatus;
        statusLoad_d = 1'b1;
      end
      brc_pkg::ST_LJ1: begin
        target_d[13:8] = progByte[5:0];
        pc_d           = pcNext;
        state_d        = brc_pkg::ST_LJ2;
      end
      brc_pkg::ST_LJ2: begin
        pc_d = longTarget;
      end
      brc_pkg::ST_SJ1: begin
        pc_d = shortTarget;
      end
      brc_pkg::ST_RJ1: begin
        pc_d = target_q;
      end
      brc_pkg::ST_RI1: begin
        pc_d = pcNext;
        if (secOk) begin
          target_d = indTarget;
          state_d  = brc_pkg::ST_RI2;
        end else begin
          // prefix belongs to another two-byte instruction
          otherValid_d = 1'b1;
        end
      end
      brc_pkg::ST_RI2: begin
        pc_d = target_q;
      end
      default: begin
        state_d = brc_pkg::ST_DECODE;
      end
    endcase
  end

  // sequencer and program counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= brc_pkg::ST_DECODE;
      pc_q     <= `BRC_PC_RESET;
      target_q <= `BRC_PC_RESET;
    end else begin
      state_q  <= state_d;
      pc_q     <= pc_d;
      target_q <= target_d;
    end
  end

  // stack pointer and restored status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_q         <= `BRC_SP_RESET;
      status_q     <= '0;
      statusLoad_q <= 1'b0;
    end else begin
      sp_q         <= sp_d;
      status_q     <= status_d;
      statusLoad_q <= statusLoad_d;
    end
  end

  // hand-over of foreign opcodes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      other_q      <= 8'h00;
      otherValid_q <= 1'b0;
    end else begin
      other_q      <= other_d;
      otherValid_q <= otherValid_d;
    end
  end

  // outputs; data registers are only read, never written; carry changes only through the return's status load
  assign fetchAddr    = pc_q;
  assign stackAddr    = sp_q + frmOff;
  assign stackPointer = sp_q;
  assign statusOut    = status_q;
  assign statusLoad   = statusLoad_q;
  assign otherOpcode  = other_q;
  assign otherValid   = otherValid_q;
  // entry only at a boundary, so a pending request waits out the return
  assign intWindow    = inDecode;
  assign busy         = !inDecode;

endmodule // brc_branch_return

`default_nettype wire

// ---- hw/brc_cfg.svh ----
// constants of the branch and return control block
`ifndef BRC_CFG_SVH
`define BRC_CFG_SVH

// first opcode bytes
`define BRC_OP_RETI      8'hD5
`define BRC_OP_LONGJ     8'hDB
`define BRC_OP_PREFIX    8'hDD
`define BRC_HI_SHORTJ    4'h9
`define BRC_HI_RELFWD    4'h1
`define BRC_HI_RELBWD    4'h0
// second opcode bytes after the prefix
`define BRC_OP2_WX       8'h64
`define BRC_OP2_EA       8'h60

// stack frame: nibble offsets from the stack pointer
`define BRC_FRM_PC_MID   8'h00
`define BRC_FRM_PC_LOW   8'h02
`define BRC_FRM_STATUS   8'h04
`define BRC_SP_STEP      8'h06

// reset values and the program counter step
`define BRC_PC_RESET     14'h0000
`define BRC_SP_RESET     8'h00
`define BRC_PC_ONE       14'h0001

// instruction cycle counts, decode cycle included
`define BRC_CYC_RETI     3
`define BRC_CYC_LONGJ    3
`define BRC_CYC_SHORTJ   2
`define BRC_CYC_RELIMM   2
`define BRC_CYC_RELIND   3

// instruction clock period
`define BRC_CLK_PERIOD_NS 50

`endif

// ---- hw/brc_opcode_decode.sv ----
// opcode classifier for the branch and return control block
`timescale 1ns/1ns
`default_nettype none
`include "brc_cfg.svh"

module brc_opcode_decode (
  input  wire logic                  [7:0] opByte,
  output brc_pkg::brc_opclass_t            opClass,
  output logic                             secIsWx,
  output logic                             secIsEa
);

  wire logic isReti   = (opByte == `BRC_OP_RETI);
  wire logic isLongj  = (opByte == `BRC_OP_LONGJ);
  wire logic isPrefix = (opByte == `BRC_OP_PREFIX);
  wire logic isShortj = (opByte[7:4] == `BRC_HI_SHORTJ);
  wire logic isFwd    = (opByte[7:4] == `BRC_HI_RELFWD);
  // a zero backward offset would be a self loop; leave it to others
  wire logic isBwd    = (opByte[7:4] == `BRC_HI_RELBWD)
                        && (opByte[3:0] != 4'h0);

  // second byte of the register-indirect jumps
  assign secIsWx = (opByte == `BRC_OP2_WX);
  assign secIsEa = (opByte == `BRC_OP2_EA);

  // classify; exact byte matches first
  assign opClass = isReti   ? brc_pkg::OC_RETI   :
                   isLongj  ? brc_pkg::OC_LONGJ  :
                   isPrefix ? brc_pkg::OC_PREFIX :
                   isShortj ? brc_pkg::OC_SHORTJ :
                   isFwd    ? brc_pkg::OC_RELFWD :
                   isBwd    ? brc_pkg::OC_RELBWD :
                              brc_pkg::OC_OTHER;

endmodule // brc_opcode_decode

`default_nettype wire

// ---- hw/brc_pkg.sv ----
// types shared by the branch and return control block
package brc_pkg;

  // opcode class seen on a first byte
  typedef enum logic [6:0] {
    OC_RETI   = 7'h01,
    OC_LONGJ  = 7'h02,
    OC_SHORTJ = 7'h04,
    OC_RELFWD = 7'h08,
    OC_RELBWD = 7'h10,
    OC_PREFIX = 7'h20,
    OC_OTHER  = 7'h40
  } brc_opclass_t;

  // sequencer states, one-hot
  typedef enum logic [8:0] {
    ST_DECODE = 9'h001,
    ST_RETI1  = 9'h002,
    ST_RETI2  = 9'h004,
    ST_LJ1    = 9'h008,
    ST_LJ2    = 9'h010,
    ST_SJ1    = 9'h020,
    ST_RJ1    = 9'h040,
    ST_RI1    = 9'h080,
    ST_RI2    = 9'h100
  } brc_state_t;

  // status restored from the interrupt frame
  typedef struct packed {
    logic       intStatHigh;
    logic       intStatLow;
    logic       memBankEn;
    logic       regBankEn;
    logic       carry;
    logic [2:0] skipCond;
  } brc_status_t;

endpackage
